// ### hw/acs_pkg.sv
package acs_pkg;
    // =========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] ACS_OFF_CSR      = 8'h00;
    localparam logic [7:0] ACS_OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] ACS_OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] ACS_OFF_SEQ_STAT = 8'h0C;

    // =========================================================
    // converter_control_status field positions
    localparam int ACS_BIT_END_FLAG  = 7;
    localparam int ACS_BIT_END_IE    = 6;
    localparam int ACS_BIT_START     = 5;
    localparam int ACS_BIT_SCAN      = 4;
    localparam int ACS_BIT_SPEED     = 3;
    localparam int ACS_BIT_CH_TOP    = 2;
    localparam int ACS_CSR_W         = 8;
    localparam logic [7:0] ACS_CSR_RESET = 8'h00;

    // =========================================================
    // event status / mask layout
    localparam int ACS_EVT_CONV_DONE = 0;
    localparam int ACS_EVT_PASS_END  = 1;
    localparam int ACS_EVT_W         = 2;
    localparam logic [1:0] ACS_EVT_RESET = 2'h0;

    // =========================================================
    // conversion timing: one state is one clock period
    localparam int ACS_CLK_MHZ         = 200;
    localparam int ACS_CLK_PER_STATE   = 1;
    localparam int ACS_CONV_STATES_SLW = 266;
    localparam int ACS_CONV_STATES_FST = 134;
    localparam int ACS_CONV_CYC_SLW    = ACS_CONV_STATES_SLW * ACS_CLK_PER_STATE;
    localparam int ACS_CONV_CYC_FST    = ACS_CONV_STATES_FST * ACS_CLK_PER_STATE;
    localparam int ACS_CNT_W           = 9;

    // =========================================================
    // sequencer states
    typedef enum logic {
        ACS_ST_IDLE,
        ACS_ST_CONV
    } acs_state_t;
endpackage

// ### hw/acs_adc_control_status.sv
// Behaviour
// - In single mode the end flag is set when the one requested conversion finishes.
// - In scan mode the end flag is set once every channel of the group was converted this pass.
// - The end flag clears only after software read it as 1 and then wrote 0 to it.
// - Writing 1 to the end flag is ignored; a write of 0 can only clear it.
// - With top select at 0, scan covers inputs 0 to the low code; single takes that input.
// - With top select at 1, scan covers inputs 4 to 4 plus the low code; single takes it.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acs_adc_control_status
    import acs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [2:0]  analog_input,
    output logic             conversion_active,
    output logic             conversion_done,
    output logic             conversion_end_irq,
    output logic             irq
);

    // =========================================================
    // apb slave
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        acc;
    logic        wr_csr;
    logic        rd_csr;
    logic        wr_stat;
    logic        wr_mask;
    logic        mapped;

    // control / status fields
    logic        flag_q;
    logic        ie_q;
    logic        start_q;
    logic        scan_q;
    logic        speed_q;
    logic [2:0]  sel_q;
    logic        armed_q;
    logic [ACS_EVT_W-1:0] stat_q;
    logic [ACS_EVT_W-1:0] mask_q;

    // sequencer
    acs_state_t  st_q;
    logic [ACS_CNT_W-1:0] cnt_q;
    logic [2:0]  ch_q;
    logic [2:0]  ch_last;
    logic [2:0]  ch_base;
    logic        load_evt;
    logic        done_evt;
    logic        pass_end;
    logic        flag_set;
    logic        irq_q;
    logic        eirq_q;
    logic        done_q;

    assign mapped = (paddr == ACS_OFF_CSR) || (paddr == ACS_OFF_IRQ_STAT) ||
                    (paddr == ACS_OFF_IRQ_MASK) || (paddr == ACS_OFF_SEQ_STAT);
    // access edge: the only edge at which writes land and reads count
    assign acc     = psel && penable && pready_q;
    assign wr_csr  = acc && pwrite && (paddr == ACS_OFF_CSR);
    assign rd_csr  = acc && !pwrite && (paddr == ACS_OFF_CSR);
    assign wr_stat = acc && pwrite && (paddr == ACS_OFF_IRQ_STAT);
    assign wr_mask = acc && pwrite && (paddr == ACS_OFF_IRQ_MASK);

    // ready is raised in setup so the access phase has zero wait states
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
        end
    end

    // read data captured in setup, held through the access phase
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                ACS_OFF_CSR:      prdata_q <= {24'h00_0000, flag_q, ie_q, start_q,
                                               scan_q, speed_q, sel_q};
                ACS_OFF_IRQ_STAT: prdata_q <= {30'h0000_0000, stat_q};
                ACS_OFF_IRQ_MASK: prdata_q <= {30'h0000_0000, mask_q};
                ACS_OFF_SEQ_STAT: prdata_q <= {27'h000_0000, (st_q == ACS_ST_CONV),
                                               1'b0, ch_q};
                default:          prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // control fields written by software
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ie_q    <= ACS_CSR_RESET[ACS_BIT_END_IE];
            scan_q  <= ACS_CSR_RESET[ACS_BIT_SCAN];
            speed_q <= ACS_CSR_RESET[ACS_BIT_SPEED];
            sel_q   <= ACS_CSR_RESET[ACS_BIT_CH_TOP:0];
        end else if (wr_csr) begin
            ie_q    <= pwdata[ACS_BIT_END_IE];
            scan_q  <= pwdata[ACS_BIT_SCAN];
            speed_q <= pwdata[ACS_BIT_SPEED];
            sel_q   <= pwdata[ACS_BIT_CH_TOP:0];
        end
    end

    // start bit: software write wins over the automatic clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            start_q <= ACS_CSR_RESET[ACS_BIT_START];
        end else if (wr_csr) begin
            start_q <= pwdata[ACS_BIT_START];
        end else if (done_evt && !scan_q) begin
            start_q <= 1'b0;
        end
    end

    // arm on the flag value the read returned, not the live flag: a set
    // between the setup and access edges must not arm an unseen flag
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
        end else if (wr_csr) begin
            armed_q <= 1'b0;
        end else if (rd_csr && prdata_q[ACS_BIT_END_FLAG]) begin
            armed_q <= 1'b1;
        end
    end

    // end flag: set wins over clear, a written 1 does nothing
    assign flag_set = done_evt && (!scan_q || pass_end);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q <= ACS_CSR_RESET[ACS_BIT_END_FLAG];
        end else if (flag_set) begin
            flag_q <= 1'b1;
        end else if (wr_csr && !pwdata[ACS_BIT_END_FLAG] && armed_q) begin
            flag_q <= 1'b0;
        end
    end

    // =========================================================
    // channel sequencer
    assign ch_base  = {sel_q[ACS_BIT_CH_TOP], 2'b00};
    assign ch_last  = sel_q;
    assign pass_end = (ch_q == ch_last);
    assign done_evt = (st_q == ACS_ST_CONV) && start_q && (cnt_q == '0);
    assign load_evt = ((st_q == ACS_ST_IDLE) && start_q) || (done_evt && scan_q);

    // clearing start mid-conversion aborts without setting the flag
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ACS_ST_IDLE;
        end else begin
            unique case (st_q)
                ACS_ST_IDLE: if (start_q) begin
                    st_q <= ACS_ST_CONV;
                end
                ACS_ST_CONV: if (!start_q || (done_evt && !scan_q)) begin
                    st_q <= ACS_ST_IDLE;
                end
            endcase
        end
    end

    // conversion timer, reloaded per channel from the current speed
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (load_evt) begin
            cnt_q <= speed_q ? ACS_CNT_W'(ACS_CONV_CYC_FST - 1)
                             : ACS_CNT_W'(ACS_CONV_CYC_SLW - 1);
        end else if (st_q == ACS_ST_CONV && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // channel pointer: single takes the code, scan walks base..last
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ch_q <= 3'h0;
        end else if (st_q == ACS_ST_IDLE && start_q) begin
            ch_q <= scan_q ? ch_base : sel_q;
        end else if (done_evt && scan_q) begin
            ch_q <= pass_end ? ch_base : ch_q + 3'h1;
        end
    end

    // =========================================================
    // event status (write one to clear, set wins) and mask
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= ACS_EVT_RESET;
        end else begin
            stat_q[ACS_EVT_CONV_DONE] <= done_evt ||
                (stat_q[ACS_EVT_CONV_DONE] && !(wr_stat && pwdata[ACS_EVT_CONV_DONE]));
            stat_q[ACS_EVT_PASS_END]  <= flag_set ||
                (stat_q[ACS_EVT_PASS_END] && !(wr_stat && pwdata[ACS_EVT_PASS_END]));
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= ACS_EVT_RESET;
        end else if (wr_mask) begin
            mask_q <= pwdata[ACS_EVT_W-1:0];
        end
    end

    // registered outputs
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q  <= 1'b0;
            eirq_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            irq_q  <= |(stat_q & mask_q);
            eirq_q <= flag_q && ie_q;
            done_q <= done_evt;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign analog_input       = ch_q;
    assign conversion_active  = (st_q == ACS_ST_CONV);
    assign conversion_done    = done_q;
    assign conversion_end_irq = eirq_q;
    assign irq                = irq_q;

    // =========================================================
    // checks
    logic [ACS_CNT_W-1:0] len_q;
    logic                 spd_lat_q;
    localparam int LIM_SLW = ACS_CONV_CYC_SLW;
    localparam int LIM_FST = ACS_CONV_CYC_FST;

    // helper: cycles spent on the current channel
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            len_q     <= '0;
            spd_lat_q <= 1'b0;
        end else if (load_evt) begin
            len_q     <= '0;
            spd_lat_q <= speed_q;
        end else if (st_q == ACS_ST_CONV) begin
            len_q <= len_q + 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_single_flag;
        done_evt && !scan_q |=> flag_q && !stat_q[ACS_EVT_CONV_DONE] == 1'b0;
    endproperty
    a_single_flag: assert property (p_single_flag) else $error("single end not flagged");

    property p_scan_flag;
        done_evt && scan_q && !pass_end && !flag_q && !wr_csr |=> !flag_q;
    endproperty
    a_scan_flag: assert property (p_scan_flag) else $error("flag set mid pass");

    property p_scan_pass;
        done_evt && scan_q && pass_end |=> flag_q ##0 ch_q == $past(ch_base);
    endproperty
    a_scan_pass: assert property (p_scan_pass) else $error("pass end wrong");

    property p_clear_seq;
        $fell(flag_q) |-> $past(wr_csr && !pwdata[ACS_BIT_END_FLAG] && armed_q);
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("flag cleared w/o sequence");

    property p_write_one;
        wr_csr && pwdata[ACS_BIT_END_FLAG] && !flag_q && !flag_set |=> !flag_q;
    endproperty
    a_write_one: assert property (p_write_one) else $error("write 1 set flag");

    property p_time_slow;
        done_evt && !spd_lat_q |-> len_q == ACS_CNT_W'(LIM_SLW - 1);
    endproperty
    a_time_slow: assert property (p_time_slow) else $error("slow conversion length");

    property p_time_fast;
        done_evt && spd_lat_q |-> len_q == ACS_CNT_W'(LIM_FST - 1);
    endproperty
    a_time_fast: assert property (p_time_fast) else $error("fast conversion length");

    property p_group_low;
        st_q == ACS_ST_IDLE && start_q && scan_q && !sel_q[2] |=> ch_q == 3'h0;
    endproperty
    a_group_low: assert property (p_group_low) else $error("low group base");

    property p_group_high;
        st_q == ACS_ST_IDLE && start_q && !scan_q && sel_q[2] |=> ch_q == $past(sel_q);
    endproperty
    a_group_high: assert property (p_group_high) else $error("single channel wrong");

    property p_auto_stop;
        done_evt && !scan_q && !wr_csr |=> !start_q ##1 st_q == ACS_ST_IDLE;
    endproperty
    a_auto_stop: assert property (p_auto_stop) else $error("start not cleared");

    property p_end_irq;
        flag_q && ie_q ##1 flag_q && ie_q |-> conversion_end_irq;
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("end irq missing");

    property p_end_irq_off;
        !(flag_q && ie_q) |=> !conversion_end_irq;
    endproperty
    a_end_irq_off: assert property (p_end_irq_off) else $error("end irq spurious");

    c_single: cover property (done_evt && !scan_q);
    c_scan_wrap: cover property (done_evt && scan_q && pass_end && sel_q == 3'h7);
    c_clear: cover property ($fell(flag_q));
    c_set_clear: cover property (flag_set && wr_csr && armed_q);

endmodule // acs_adc_control_status
`default_nettype wire

// ### tb/acs_adc_control_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acs_adc_control_status_tb
    import acs_pkg::*;
;
    // =========================================================
    // stimulus and observed signals
    logic        clock;
    logic        sys_rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  analog_input;
    logic        conversion_active;
    logic        conversion_done;
    logic        conversion_end_irq;
    logic        irq;
    int          bad_count;
    int          total_checks;
    int          act_len;
    int          done_cnt;
    logic [2:0]  chq[$];
    logic [31:0] rd;
    logic        er;

    acs_adc_control_status u_acs_adc_control_status (
        .clock              (clock),
        .sys_rst            (sys_rst),
        .paddr              (paddr),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .analog_input       (analog_input),
        .conversion_active  (conversion_active),
        .conversion_done    (conversion_done),
        .conversion_end_irq (conversion_end_irq),
        .irq                (irq)
    );

    // 200 mhz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // =========================================================
    // compare and verdict
    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // =========================================================
    // apb master: values read right after the edge are pre-edge samples
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk1("pready_seen", 1'b1, pready);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk32(nm, exp, rd);
    endtask

    // registered irq outputs need two edges to follow a write
    task automatic settle;
        repeat (2) @(posedge clock);
    endtask

    // record busy cycles and channel order until the end request rises
    task automatic watch(input int limit);
        int n;
        n = 0;
        act_len = 0;
        done_cnt = 0;
        chq.delete();
        while (conversion_end_irq !== 1'b1 && n < limit) begin
            @(posedge clock);
            n++;
            if (conversion_done === 1'b1) done_cnt++;
            if (conversion_active === 1'b1) begin
                act_len++;
                if (chq.size() == 0 || chq[$] !== analog_input) chq.push_back(analog_input);
            end
        end
        chk1("end_irq_in_time", 1'b1, conversion_end_irq);
    endtask

    // scan one group, then stop it by writing start low
    task automatic run_scan(input logic [7:0] csr, input logic [2:0] base);
        apb(1'b1, ACS_OFF_CSR, {24'h0, csr});
        rd_chk(ACS_OFF_SEQ_STAT, {27'h0, 2'b10, base}, "seq_stat_busy");
        watch(3000);
        chk1("scan_count", 1'b1, chq.size() >= 4 && chq.size() <= 5);
        chk32("scan_done_pulses", 32'd4, done_cnt);
        for (int i = 0; i < 4; i++) chk32("scan_ch", {29'h0, base + 3'(i)}, {29'h0, chq[i]});
        rd_chk(ACS_OFF_CSR, {24'h0, csr | 8'h80}, "scan_flag_start");
        apb(1'b1, ACS_OFF_CSR, {24'h0, csr & 8'hDF});
        settle();
        chk1("scan_stopped", 1'b0, conversion_active);
        rd_chk(ACS_OFF_CSR, {24'h0, csr & 8'hDF}, "scan_csr_after_stop");
        $display("test scan from %0d done", base);
    endtask

    // =========================================================
    // main sequence
    initial begin
        sys_rst      = 1'b1;
        paddr        = 8'h00;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        pwdata       = 32'h0000_0000;
        bad_count    = 0;
        total_checks = 0;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(ACS_OFF_CSR, 32'h0, "csr_reset");
        chk1("mapped_no_err", 1'b0, er);
        rd_chk(ACS_OFF_IRQ_STAT, 32'h0, "stat_reset");
        rd_chk(ACS_OFF_IRQ_MASK, 32'h0, "mask_reset");
        rd_chk(ACS_OFF_SEQ_STAT, 32'h0, "seq_reset");
        apb(1'b1, ACS_OFF_CSR, 32'h0000_0080);
        rd_chk(ACS_OFF_CSR, 32'h0, "flag_write_one");
        rd_chk(8'h10, 32'h0, "unmapped_read");
        chk1("unmapped_err", 1'b1, er);
        $display("test reset and map done");
        // single, slow, input 5, request enabled
        apb(1'b1, ACS_OFF_CSR, 32'h0000_0065);
        watch(2000);
        chk1("slow_len", 1'b1, act_len > 0 && act_len <= ACS_CONV_STATES_SLW);
        chk32("single_cnt", 32'd1, chq.size());
        chk32("single_done_pulses", 32'd1, done_cnt);
        chk32("single_ch5", 32'd5, {29'h0, chq[0]});
        apb(1'b1, ACS_OFF_CSR, 32'h0000_0085);
        settle();
        chk1("irq_enable_off", 1'b0, conversion_end_irq);
        rd_chk(ACS_OFF_CSR, 32'h85, "flag_kept_start_cleared");
        apb(1'b1, ACS_OFF_CSR, 32'h0000_00C5);
        apb(1'b1, ACS_OFF_CSR, 32'h0000_0045);
        settle();
        rd_chk(ACS_OFF_CSR, 32'hC5, "flag_needs_read");
        chk1("irq_enabled", 1'b1, conversion_end_irq);
        apb(1'b1, ACS_OFF_CSR, 32'h0000_0045);
        settle();
        chk1("irq_after_clear", 1'b0, conversion_end_irq);
        rd_chk(ACS_OFF_CSR, 32'h45, "flag_cleared");
        $display("test single slow done");
        // event status, mask and the level interrupt
        rd_chk(ACS_OFF_IRQ_STAT, 32'h3, "evt_status");
        chk1("irq_masked", 1'b0, irq);
        apb(1'b1, ACS_OFF_IRQ_MASK, 32'h0000_0003);
        settle();
        chk1("irq_unmasked", 1'b1, irq);
        apb(1'b1, ACS_OFF_IRQ_STAT, 32'h0000_0001);
        rd_chk(ACS_OFF_IRQ_STAT, 32'h2, "evt_w1c");
        chk1("irq_one_left", 1'b1, irq);
        apb(1'b1, ACS_OFF_IRQ_STAT, 32'h0000_0002);
        settle();
        chk1("irq_all_clear", 1'b0, irq);
        rd_chk(ACS_OFF_IRQ_MASK, 32'h3, "mask_readback");
        $display("test events done");
        // single, fast, input 2
        apb(1'b1, ACS_OFF_CSR, 32'h0000_006A);
        watch(1000);
        chk1("fast_len", 1'b1, act_len > 0 && act_len <= ACS_CONV_STATES_FST);
        chk32("single_ch2", 32'd2, {29'h0, chq[0]});
        chk32("fast_done_pulses", 32'd1, done_cnt);
        rd_chk(ACS_OFF_CSR, 32'hCA, "fast_end");
        apb(1'b1, ACS_OFF_CSR, 32'h0000_004A);
        $display("test single fast done");
        run_scan(8'h73, 3'd0);
        run_scan(8'h7F, 3'd4);
        give_verdict();
    end

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (50000) @(posedge clock);
        bad_count++;
        $display("mismatch watchdog expected finish seen hang");
        give_verdict();
    end
endmodule // acs_adc_control_status_tb
`default_nettype wire
